// ==== pkg/read_param_defines.vh ====
/*
  Constants for the read parameter register block: instruction codes,
  field positions, reset values and default dummy counts.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef READ_PARAM_DEFINES_VH
`define READ_PARAM_DEFINES_VH

// ==========================================================
// Register layout
`define RP_RESET_VALUE 8'h00
`define RP_PIN_SEL_BIT 7
`define RP_DUMMY_MSB 6
`define RP_DUMMY_LSB 3
`define RP_WRAP_EN_BIT 2
`define RP_BURST_HIGH_BIT 1
`define RP_BURST_LOW_BIT 0

// ==========================================================
// Instruction codes
`define CMD_SET_RP_PERSISTENT 8'h65
`define CMD_SET_RP_TEMP_A 8'hC0
`define CMD_SET_RP_TEMP_B 8'h63
`define CMD_FAST_READ 8'h0B
`define CMD_FAST_READ_DDR 8'h0D
`define CMD_DUAL_OUT_READ 8'h3B
`define CMD_DUAL_IO_READ 8'hBB
`define CMD_DUAL_IO_READ_DDR 8'hBD
`define CMD_QUAD_OUT_READ 8'h6B
`define CMD_QUAD_IO_READ 8'hEB
`define CMD_QUAD_IO_READ_DDR 8'hED

// ==========================================================
// Frame lengths and default dummy counts
`define WRITE_FRAME_BITS 5'd16
`define OPCODE_BITS 5'd8
`define DUMMY_DEF_SERIAL 4'd8
`define DUMMY_DEF_QPI 4'd6
`define DUMMY_DEF_QUAD_IO 4'd6
`define DUMMY_DEF_DUAL_IO 4'd4
`define DUMMY_DEF_OUTPUT 4'd8

`endif

// ==== rtl/read_parameter_register.v ====
/*
  Read parameter register of a serial flash: persistent and temporary
  copies, written by the set-read-parameters instructions seen on the
  serial pins, and decoded into pin function, dummy count and wrap.
  Assumes the serial pins arrive asynchronous to clk_sys and that the
  serial clock runs well below a quarter of the clk_sys rate.
*/
`timescale 1ns/10ps
`default_nettype none
`include "read_param_defines.vh"

module read_parameter_register
(
  // System
  input wire clk_sys,
  input wire rst_n,
  // Power state and straps
  input wire cold_start,
  input wire dedicated_reset_variant,
  input wire quad_lane_enable,
  input wire qpi_mode,
  // Serial pins, input halves only
  input wire sck,
  input wire cs_n,
  input wire [3:0] io_in,
  // Register contents
  output reg [7:0] read_option_reg,
  output reg [7:0] read_option_persistent,
  // Shared pin function
  output reg shared_pin_is_hold,
  output reg shared_pin_is_reset,
  output reg shared_pin_is_data,
  // Settings of the frame in progress
  output reg [7:0] frame_opcode,
  output reg frame_opcode_valid,
  output reg frame_is_read,
  output reg [3:0] frame_dummy_cycles,
  output reg frame_wrap_enable,
  output reg [6:0] frame_burst_bytes,
  // Pulse when a set instruction completes
  output reg write_done
);

  // ==========================================================
  // Synchronisers and edge detect
  reg [1:0] sck_sync;
  reg [1:0] cs_sync;
  reg [3:0] io_meta;
  reg [3:0] io_sync;
  reg sck_prev;
  reg cs_prev;
  reg strap_seen;
  reg dedicated_reset;
  reg [1:0] strap_sync;
  wire sck_rise;
  wire frame_start;
  wire frame_end;

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sck_sync <= 2'b00;
      cs_sync <= 2'b11;
      io_meta <= 4'h0;
      io_sync <= 4'h0;
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end
    else
    begin
      sck_sync <= {sck_sync[0], sck};
      cs_sync <= {cs_sync[0], cs_n};
      io_meta <= io_in;
      io_sync <= io_meta;
      sck_prev <= sck_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  assign sck_rise = sck_sync[1] & ~sck_prev & ~cs_sync[1];
  assign frame_start = cs_prev & ~cs_sync[1];
  assign frame_end = ~cs_prev & cs_sync[1];

  // Strap pin synchronised without reset so it has settled by release
  always @(posedge clk_sys)
  begin
    strap_sync <= {strap_sync[0], dedicated_reset_variant};
  end

  // Strap caught once after reset release, never under reset itself
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      strap_seen <= 1'b0;
      dedicated_reset <= 1'b0;
    end
    else if (!strap_seen)
    begin
      strap_seen <= 1'b1;
      dedicated_reset <= strap_sync[1];
    end
  end

  // ==========================================================
  // Frame shifter: opcode then one data byte
  reg [15:0] shift;
  reg [4:0] bit_count;
  reg overrun;
  reg [4:0] next_bit_count;
  reg [15:0] next_shift;

  always @*
  begin
    if (qpi_mode)
    begin
      next_shift = {shift[11:0], io_sync};
      next_bit_count = bit_count + 5'd4;
    end
    else
    begin
      next_shift = {shift[14:0], io_sync[0]};
      next_bit_count = bit_count + 5'd1;
    end
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      shift <= 16'h0000;
      bit_count <= 5'd0;
      overrun <= 1'b0;
    end
    else if (frame_start)
    begin
      shift <= 16'h0000;
      bit_count <= 5'd0;
      overrun <= 1'b0;
    end
    else if (sck_rise)
    begin
      shift <= next_shift;
      if (bit_count >= `WRITE_FRAME_BITS)
        overrun <= 1'b1;
      else
        bit_count <= next_bit_count;
    end
  end

  // ==========================================================
  // Register copies
  wire opcode_done;
  wire is_persistent_write;
  wire is_temp_write;
  wire write_ok;
  reg loaded;

  assign opcode_done = sck_rise & (next_bit_count == `OPCODE_BITS);
  assign is_persistent_write = shift[15:8] == `CMD_SET_RP_PERSISTENT;
  assign is_temp_write = (shift[15:8] == `CMD_SET_RP_TEMP_A) |
                         (shift[15:8] == `CMD_SET_RP_TEMP_B);
  // Whole byte only; a short or long frame is dropped as a unit
  assign write_ok = frame_end & ~overrun &
                    (bit_count == `WRITE_FRAME_BITS);

  // Persistent copy survives warm resets; only cold start clears it
  always @(posedge clk_sys)
  begin
    if (!rst_n && cold_start)
      read_option_persistent <= `RP_RESET_VALUE;
    else if (rst_n && write_ok && is_persistent_write)
      read_option_persistent <= shift[7:0];
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      read_option_reg <= `RP_RESET_VALUE;
      loaded <= 1'b0;
      write_done <= 1'b0;
    end
    else
    begin
      write_done <= write_ok & (is_persistent_write | is_temp_write);
      if (!loaded)
      begin
        loaded <= 1'b1;
        read_option_reg <= read_option_persistent;
      end
      else if (write_ok && is_temp_write)
        read_option_reg <= shift[7:0];
    end
  end

  // ==========================================================
  // Shared pin function, from the temporary copy
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      shared_pin_is_hold <= 1'b1;
      shared_pin_is_reset <= 1'b0;
      shared_pin_is_data <= 1'b0;
    end
    else
    begin
      shared_pin_is_data <= quad_lane_enable;
      shared_pin_is_hold <= ~quad_lane_enable &
        (dedicated_reset | ~read_option_reg[`RP_PIN_SEL_BIT]);
      shared_pin_is_reset <= ~quad_lane_enable & ~dedicated_reset &
        read_option_reg[`RP_PIN_SEL_BIT];
    end
  end

  // ==========================================================
  // Per-frame read settings, frozen at frame start
  reg [7:0] held_option;
  reg [3:0] next_default;
  reg next_is_read;
  wire [7:0] opcode_now;
  wire [3:0] field_dummy;

  assign opcode_now = next_shift[7:0];
  assign field_dummy = held_option[`RP_DUMMY_MSB:`RP_DUMMY_LSB];

  always @*
  begin
    next_is_read = 1'b1;
    next_default = `DUMMY_DEF_SERIAL;
    case (opcode_now)
      `CMD_FAST_READ, `CMD_FAST_READ_DDR:
        next_default = qpi_mode ? `DUMMY_DEF_QPI
                                : `DUMMY_DEF_SERIAL;
      `CMD_DUAL_OUT_READ, `CMD_QUAD_OUT_READ:
        next_default = `DUMMY_DEF_OUTPUT;
      `CMD_DUAL_IO_READ, `CMD_DUAL_IO_READ_DDR:
        next_default = `DUMMY_DEF_DUAL_IO;
      `CMD_QUAD_IO_READ, `CMD_QUAD_IO_READ_DDR:
        next_default = `DUMMY_DEF_QUAD_IO;
      default:
        next_is_read = 1'b0;
    endcase
  end

  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      held_option <= `RP_RESET_VALUE;
      frame_opcode <= 8'h00;
      frame_opcode_valid <= 1'b0;
      frame_is_read <= 1'b0;
      frame_dummy_cycles <= 4'h0;
      frame_wrap_enable <= 1'b0;
      frame_burst_bytes <= 7'd8;
    end
    else if (frame_start)
    begin
      // A write landing mid-read waits for the next frame
      held_option <= read_option_reg;
      frame_opcode_valid <= 1'b0;
      frame_is_read <= 1'b0;
      frame_wrap_enable <= read_option_reg[`RP_WRAP_EN_BIT];
      case (read_option_reg[`RP_BURST_HIGH_BIT:`RP_BURST_LOW_BIT])
        2'b00: frame_burst_bytes <= 7'd8;
        2'b01: frame_burst_bytes <= 7'd16;
        2'b10: frame_burst_bytes <= 7'd32;
        default: frame_burst_bytes <= 7'd64;
      endcase
    end
    else if (opcode_done)
    begin
      frame_opcode <= opcode_now;
      frame_opcode_valid <= 1'b1;
      frame_is_read <= next_is_read;
      if (field_dummy == 4'h0)
        frame_dummy_cycles <= next_default;
      else
        frame_dummy_cycles <= field_dummy;
    end
  end

endmodule
`default_nettype wire

// ==== dv/read_parameter_register_chk.sv ====
/* Port assertions for the read parameter register.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Checker
module read_parameter_register_chk (
  // System
  input wire clk_sys,
  input wire rst_n,
  input wire quad_lane_enable,
  input wire dedicated_reset_variant,
  // Observed outputs
  input wire [7:0] read_option_reg,
  input wire [7:0] read_option_persistent,
  input wire shared_pin_is_hold,
  input wire shared_pin_is_reset,
  input wire shared_pin_is_data,
  input wire frame_opcode_valid,
  input wire frame_is_read,
  input wire [3:0] frame_dummy_cycles,
  input wire write_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_reset_value:
    assert property ($rose(rst_n) |-> !read_option_reg && shared_pin_is_hold)
    else $error("register not cleared by reset");
  chk_power_load:
    assert property ($rose(rst_n) |=> read_option_reg ==
      $past(read_option_persistent)) else $error("no load at power-up");
  chk_done_pulse:
    assert property (write_done |=> !write_done)
    else $error("write pulse longer than one cycle");
  chk_temp_stable:
    assert property (!write_done && $past(rst_n, 2) |->
      $stable(read_option_reg)) else $error("active copy changed alone");
  chk_nv_stable:
    assert property (!write_done |-> $stable(read_option_persistent))
    else $error("persistent copy changed alone");
  chk_pin_select:
    assert property ($past(!quad_lane_enable && rst_n) |->
      shared_pin_is_reset == ($past(read_option_reg[7]) &&
      !dedicated_reset_variant)) else $error("shared pin function wrong");
  chk_quad_data:
    assert property ($past(quad_lane_enable && rst_n) |->
      shared_pin_is_data && !shared_pin_is_reset)
    else $error("quad lanes not data");
  chk_dummy_set:
    assert property (frame_opcode_valid && frame_is_read |->
      frame_dummy_cycles != 4'h0) else $error("read with no dummy count");
  cover property (write_done);
  cover property (frame_opcode_valid && frame_is_read);
  cover property (shared_pin_is_data);
endmodule
bind read_parameter_register read_parameter_register_chk chk_u (.clk_sys,
  .rst_n, .quad_lane_enable, .dedicated_reset_variant,
  .read_option_reg, .read_option_persistent,
  .shared_pin_is_hold, .shared_pin_is_reset, .shared_pin_is_data,
  .frame_opcode_valid, .frame_is_read, .frame_dummy_cycles, .write_done);
`default_nettype wire

// ==== dv/spi_host_model.sv ====
/* Host side of the serial link: sends frames of bits or nibbles.
   Assumes the device shifts data in on the rising serial clock. */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Host model
module spi_host_model (
  // Serial pins
  output var logic sck,
  output var logic cs_n,
  output var logic [3:0] io
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    io = 4'h0;
  end
  // 80 ns period, twenty clk_sys periods, keeps sck well below a quarter of the clk_sys rate
  task automatic send(input logic [15:0] fr, input int n, input logic q);
    cs_n = 1'b0;
    for (int k = 0; k < n; k++)
    begin
      io = q ? fr[15-4*k -: 4] : {~io[3:1], fr[15-k]};
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Released lines must not keep the last value
    io = ~io;
    #240;
  endtask
endmodule
`default_nettype wire

// ==== dv/read_parameter_register_test.sv ====
/* Self-checking bench for the read parameter register.
   Assumes the host model drives the serial pins. */
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Bench
module read_parameter_register_test;
  logic clk_sys = 0, rst_n = 0, cold_start = 1, qe = 0, qpi = 0;
  logic [7:0] temp = 0, pers = 0;
  logic variant = 0;
  logic [7:0] codes[3] = '{8'hC0, 8'h63, 8'h65};
  logic [7:0] rd[4] = '{8'h0B, 8'hBB, 8'hEB, 8'h6B};
  logic [3:0] dflt[4] = '{4'd8, 4'd4, 4'd6, 4'd8};
  logic [15:0] notes[$];
  logic [15:0] e;
  wire sck, cs_n, hold, rpin, dpin, is_rd, wrap, write_done;
  wire [3:0] io, dummy;
  wire [6:0] burst;
  wire [7:0] act, nv;
  int failures = 0, check_count = 0;
  read_parameter_register dut_u (.clk_sys, .rst_n, .cold_start,
    .dedicated_reset_variant(variant), .quad_lane_enable(qe), .qpi_mode(qpi),
    .sck, .cs_n, .io_in(io), .read_option_reg(act),
    .read_option_persistent(nv), .shared_pin_is_hold(hold),
    .shared_pin_is_reset(rpin), .shared_pin_is_data(dpin),
    .frame_opcode(), .frame_opcode_valid(), .frame_is_read(is_rd),
    .frame_dummy_cycles(dummy), .frame_wrap_enable(wrap),
    .frame_burst_bytes(burst), .write_done);
  spi_host_model host_u (.sck, .cs_n, .io);
  task automatic check(input string what, input logic [7:0] ex, got);
    check_count++;
    if (got !== ex)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    if (op == 8'h65) pers = d;
    else temp = d;
    notes.push_back({temp, pers});
    host_u.send({op, d}, qpi ? 4 : 16, qpi);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  // ============================================================
  // Result watcher
  always @(negedge clk_sys)
    if (write_done === 1'b1)
    begin
      e = notes.size() ? notes.pop_front() : 16'hxxxx;
      check("active copy", e[15:8], act);
      check("persistent copy", e[7:0], nv);
    end
  initial
  begin
    #60000;
    failures++;
    summarize;
  end
  // ============================================================
  // Tests
  initial
  begin
    void'($urandom(30));
    repeat (4) @(negedge clk_sys);
    rst_n = 1;
    repeat (4) @(negedge clk_sys);
    check("reset value", 8'h00, act);
    check("hold pin", 8'h01, hold);
    $display("reset test done");
    for (int k = 0; k < 6; k++)
    begin
      qpi = k[0];
      wr(codes[k % 3], 8'($urandom));
    end
    qpi = 0;
    host_u.send({8'hC0, 8'h5A}, 15, 1'b0);
    check("short frame", temp, act);
    $display("write test done");
    rst_n = 0;
    cold_start = 0;
    repeat (4) @(negedge clk_sys);
    rst_n = 1;
    repeat (4) @(negedge clk_sys);
    temp = pers;
    check("power-up load", pers, act);
    $display("power-up test done");
    for (int i = 0; i < 2; i++)
    begin
      wr(8'hC0, i ? 8'h29 : 8'h07);
      for (int k = 0; k < 4; k++)
      begin
        host_u.send({rd[k], 8'h00}, 8, 1'b0);
        check("read opcode", 8'h01, is_rd);
        check("dummy", i ? 4'd5 : dflt[k], dummy);
        check("burst", i ? 7'd16 : 7'd64, burst);
        check("wrap", 8'(i == 0), wrap);
      end
      qpi = 1;
      host_u.send({8'h0B, 8'h00}, 2, 1'b1);
      check("qpi dummy", i ? 4'd5 : 4'd6, dummy);
      qpi = 0;
    end
    $display("read setting test done");
    wr(8'hC0, 8'h80);
    check("reset pin", 8'h01, rpin);
    qe = 1;
    repeat (4) @(negedge clk_sys);
    check("data pin", 8'h01, dpin);
    check("pending", 8'h00, 8'(notes.size()));
    $display("pin test done");
    rst_n = 0;
    qe = 0;
    variant = 1;
    repeat (4) @(negedge clk_sys);
    rst_n = 1;
    repeat (4) @(negedge clk_sys);
    wr(8'hC0, 8'h80);
    check("dedicated hold", 8'h01, hold);
    check("dedicated reset", 8'h00, rpin);
    $display("variant test done");
    summarize;
  end
endmodule
`default_nettype wire
